// ---- bmrc_dec_model.sv ----
// Stand-in for the bus word decoder that feeds the monitor
`timescale 1ns/1ps
module bmrc_dec_model
  import bmrc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic [TT_W-1:0] i_time_tag,
  output logic o_sync,
  output logic o_sync_cmd,
  output logic o_mid,
  output logic [4:0] o_idx,
  output logic o_two,
  output logic o_done,
  output logic o_manch,
  output logic o_par,
  output logic o_cmd,
  output logic [15:0] o_data,
  output logic o_end
);
  logic [TT_W-1:0] t_first = TT_ZERO;
  logic [TT_W-1:0] t_last = TT_ZERO;
  initial begin
    {o_sync, o_sync_cmd, o_mid, o_two, o_done, o_manch, o_par, o_cmd, o_end} = 9'h000;
    o_idx = 5'h00;
    o_data = 16'h0000;
  end
  // ----
  // One word: sync, bit 0, two bits, bit 15, parity, done
  // ----
  task automatic send(input logic c, input logic m, input logic p, input logic [15:0] d);
    @(posedge i_sys_clk);
    o_sync <= 1'b1;
    o_sync_cmd <= c;
    @(posedge i_sys_clk);
    o_sync <= 1'b0;
    o_mid <= 1'b1;
    o_idx <= 5'h00;
    @(posedge i_sys_clk);
    t_first = i_time_tag;
    o_mid <= 1'b0;
    o_two <= 1'b1;
    @(posedge i_sys_clk);
    o_two <= 1'b0;
    o_mid <= 1'b1;
    o_idx <= 5'h0F;
    @(posedge i_sys_clk);
    t_last = i_time_tag;
    o_idx <= 5'h10;
    @(posedge i_sys_clk);
    o_mid <= 1'b0;
    o_done <= 1'b1;
    {o_manch, o_par, o_cmd, o_data} <= {m, p, c, d};
    @(posedge i_sys_clk);
    o_done <= 1'b0;
    // Qualifiers are not held after done; flip them so stale values cannot pass
    {o_manch, o_par, o_cmd, o_data} <= ~{m, p, c, d};
  endtask : send
  task automatic finish();
    @(posedge i_sys_clk);
    o_end <= 1'b1;
    @(posedge i_sys_clk);
    o_end <= 1'b0;
  endtask : finish
endmodule : bmrc_dec_model

// ---- bmrc_pkg.sv ----
// Constants, field layout and state encoding of the bus monitor record control
// How it works
// - Selector 00 stamps the time tag at the mid-bit of the last data bit of the last word of the message.
// - Selector 01 stamps the time tag at the mid-bit of the first data bit of the first word of the message.
// - Selector 10 stamps the time tag at the mid-bit of the last data bit of the first word of the message.
// - Selector 11 disables stamping and every record carries a time tag of zero.
// - The last bit is data bit 15, the one just before the parity bit, never the parity bit.
// - The first bit is data bit 0, whose mid-bit comes half a microsecond after the sync.
// - Start mode 00 opens a record only on a complete good command word and stores nothing earlier.
// - Start mode 01 opens a record on a complete good word with either sync type.
// - A record opened by a data-sync word raises the sync error flag of that message.
// - Start mode 10 opens on command sync plus two data bits and flags an invalid word if no good command word follows.
// - Start mode 11 opens on any sync plus two data bits and flags an invalid word if no good Manchester word follows.
// - With the keep bit at 0 a bad word after the first word of the record aborts the record unstored and the start condition is awaited again.
// - With the keep bit at 1 a bad word is stored and recording goes on until the message ends.
package bmrc_pkg;

  // ----------------------------------------------------------------
  // Configuration register layout
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_ADDR = 16'h0029;
  localparam logic [15:0] CFG_RESET = 16'h0801;
  localparam logic [15:0] CFG_RO_ONES = 16'h0001;
  localparam int CFG_STAMP_LSB = 8;
  localparam int CFG_START_LSB = 5;
  localparam int CFG_KEEP_BIT = 4;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] STAMP_LAST_LAST = 2'h0;
  localparam logic [1:0] STAMP_FIRST_FIRST = 2'h1;
  localparam logic [1:0] STAMP_LAST_FIRST = 2'h2;
  localparam logic [1:0] STAMP_OFF = 2'h3;
  localparam logic [1:0] START_CMD_WORD = 2'h0;
  localparam logic [1:0] START_ANY_WORD = 2'h1;
  localparam logic [1:0] START_CMD_FRAG = 2'h2;
  localparam logic [1:0] START_ANY_FRAG = 2'h3;

  // ----------------------------------------------------------------
  // Word bit positions and widths
  // ----------------------------------------------------------------
  localparam logic [4:0] FIRST_DATA_BIT = 5'h00;
  localparam logic [4:0] LAST_DATA_BIT = 5'h0F;
  localparam int TT_W = 48;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [TT_W-1:0] TT_ZERO = 48'h0000_0000_0000;

  // ----------------------------------------------------------------
  // Recorder states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_REC = 3'b100
  } bmrc_state_t;

endpackage : bmrc_pkg

// ---- bmrc_stamp.sv ----
// Time tag latch that samples the counter on the selected mid-bit event
`timescale 1ns/1ps
module bmrc_stamp
  import bmrc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  bmrc_stamp_if.unit st
);

  logic [TT_W-1:0] cand_q;
  logic [TT_W-1:0] cand_d;
  logic [TT_W-1:0] stamp_q;
  logic [TT_W-1:0] stamp_d;
  logic [4:0] event_bit;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    event_bit = (st.sel == STAMP_FIRST_FIRST) ? FIRST_DATA_BIT : LAST_DATA_BIT;
    cand_d = cand_q;
    stamp_d = stamp_q;
    // Stale candidates from a word fragment are dropped at the next sync
    if (st.sync_det) begin
      cand_d = TT_ZERO;
    end
    if (st.bit_mid && (st.bit_index == event_bit)) begin
      cand_d = st.time_tag;
    end
    if (st.clear) begin
      stamp_d = TT_ZERO;
    end
    if (st.commit_first && ((st.sel == STAMP_FIRST_FIRST) || (st.sel == STAMP_LAST_FIRST))) begin
      stamp_d = cand_q;
    end
    if (st.commit_word && (st.sel == STAMP_LAST_LAST)) begin
      stamp_d = cand_q;
    end
    if (st.sel == STAMP_OFF) begin
      stamp_d = TT_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cand_q <= TT_ZERO;
      stamp_q <= TT_ZERO;
    end else if (i_clk_en) begin
      cand_q <= cand_d;
      stamp_q <= stamp_d;
    end
  end

  assign st.stamp = stamp_q;

endmodule : bmrc_stamp

// ---- bmrc_stamp_if.sv ----
// Carrier between the recorder control and the time tag latch
`timescale 1ns/1ps
interface bmrc_stamp_if;
  import bmrc_pkg::*;
  logic [1:0] sel;
  logic sync_det;
  logic bit_mid;
  logic [4:0] bit_index;
  logic [TT_W-1:0] time_tag;
  logic clear;
  logic commit_first;
  logic commit_word;
  logic [TT_W-1:0] stamp;

  modport ctrl (
    output sel, sync_det, bit_mid, bit_index, time_tag, clear, commit_first, commit_word,
    input stamp
  );
  modport unit (
    input sel, sync_det, bit_mid, bit_index, time_tag, clear, commit_first, commit_word,
    output stamp
  );
endinterface : bmrc_stamp_if

// ---- bmrc_top.sv ----
// Capture control of the simple message monitor: start, abort and time tag of records
`timescale 1ns/1ps
module bmrc_top
  import bmrc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_cfg_we,
  input wire logic [15:0] i_cfg_wdata,
  output logic [15:0] o_cfg_rdata,
  input wire logic i_sync_det,
  input wire logic i_sync_is_cmd,
  input wire logic i_bit_mid,
  input wire logic [4:0] i_bit_index,
  input wire logic i_two_bits,
  input wire logic i_word_done,
  input wire logic i_word_manch_ok,
  input wire logic i_word_parity_ok,
  input wire logic i_word_is_cmd,
  input wire logic [15:0] i_word_data,
  input wire logic i_msg_end,
  input wire logic [TT_W-1:0] i_time_tag,
  output logic o_rec_start,
  output logic o_rec_word_vld,
  output logic [15:0] o_rec_word,
  output logic o_rec_word_is_cmd,
  output logic o_rec_end,
  output logic o_rec_abort,
  output logic [TT_W-1:0] o_stamp,
  output logic o_sync_err,
  output logic o_invalid_err,
  output logic o_recording,
  output logic [CNT_W-1:0] o_word_count
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic word_ok(input logic manch_ok, input logic parity_ok);
    word_ok = manch_ok && parity_ok;
  endfunction : word_ok

  // A complete good command word is demanded by the command-word start and by the command-fragment check
  function automatic logic good_cmd(input logic ok, input logic is_cmd);
    good_cmd = ok && is_cmd;
  endfunction : good_cmd

  // Only the modes that accept data sync can open a record on it
  function automatic logic opens_on_data(input logic [1:0] mode, input logic word_cmd, input logic sync_cmd);
    opens_on_data = (mode == START_ANY_WORD) ? !word_cmd : (mode == START_ANY_FRAG) ? !sync_cmd : 1'b0;
  endfunction : opens_on_data

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  bmrc_state_t state_q;
  bmrc_state_t state_d;
  logic sync_err_q;
  logic sync_err_d;
  logic inv_q;
  logic inv_d;
  logic start_q;
  logic start_d;
  logic wvld_q;
  logic wvld_d;
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic wcmd_q;
  logic wcmd_d;
  logic end_q;
  logic end_d;
  logic abort_q;
  logic abort_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic rec_q;
  logic rec_d;
  logic [1:0] start_mode;
  logic keep_bad;
  logic good;
  logic store_w;
  logic begin_rec;
  logic commit_first;
  logic commit_word;

  bmrc_stamp_if st_if ();

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  // Bits 7 and 3 are stored for readback only and steer nothing
  assign start_mode = cfg_q[CFG_START_LSB +: 2];
  assign keep_bad = cfg_q[CFG_KEEP_BIT];
  assign good = word_ok(i_word_manch_ok, i_word_parity_ok);

  always_comb begin
    cfg_d = cfg_q;
    if (i_cfg_we) begin
      // Bit 0 is forced here so the readback needs no gate after the register
      cfg_d = i_cfg_wdata | CFG_RO_ONES;
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= CFG_RESET;
    end else if (i_clk_en) begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // Recorder state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    sync_err_d = sync_err_q;
    inv_d = inv_q;
    start_d = 1'b0;
    wvld_d = 1'b0;
    word_d = word_q;
    wcmd_d = wcmd_q;
    end_d = 1'b0;
    abort_d = 1'b0;
    cnt_d = cnt_q;
    store_w = 1'b0;
    begin_rec = 1'b0;
    commit_first = 1'b0;
    commit_word = 1'b0;
    case (state_q)
      ST_IDLE: begin
        case (start_mode)
          START_CMD_WORD: begin
            if (i_word_done && good_cmd(good, i_word_is_cmd)) begin
              begin_rec = 1'b1;
              store_w = 1'b1;
              commit_first = 1'b1;
              state_d = ST_REC;
            end
          end
          START_ANY_WORD: begin
            if (i_word_done && good) begin
              begin_rec = 1'b1;
              store_w = 1'b1;
              commit_first = 1'b1;
              state_d = ST_REC;
            end
          end
          START_CMD_FRAG: begin
            if (i_two_bits && i_sync_is_cmd) begin
              begin_rec = 1'b1;
              state_d = ST_FIRST;
            end
          end
          default: begin
            if (i_two_bits) begin
              begin_rec = 1'b1;
              state_d = ST_FIRST;
            end
          end
        endcase
      end
      ST_FIRST: begin
        // Fragment modes keep the first word whatever its quality
        if (i_word_done) begin
          store_w = 1'b1;
          commit_first = 1'b1;
          state_d = ST_REC;
          if ((start_mode == START_CMD_FRAG) && !good_cmd(good, i_word_is_cmd)) begin
            inv_d = 1'b1;
          end
          if ((start_mode == START_ANY_FRAG) && !i_word_manch_ok) begin
            inv_d = 1'b1;
          end
        end
        if (i_msg_end) begin
          end_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_REC: begin
        if (i_word_done && good) begin
          store_w = 1'b1;
        end else if (i_word_done && keep_bad) begin
          store_w = 1'b1;
          inv_d = 1'b1;
        end else if (i_word_done) begin
          abort_d = 1'b1;
          state_d = ST_IDLE;
        end
        // Abort wins over end so a dropped record is never reported complete
        if (i_msg_end && !abort_d) begin
          end_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (begin_rec) begin
      start_d = 1'b1;
      cnt_d = '0;
      inv_d = 1'b0;
      sync_err_d = opens_on_data(start_mode, i_word_is_cmd, i_sync_is_cmd);
    end
    if (store_w) begin
      wvld_d = 1'b1;
      word_d = i_word_data;
      wcmd_d = i_word_is_cmd;
      commit_word = 1'b1;
      // Count sticks at its top value so an endless record cannot wrap back to zero
      if (begin_rec) begin
        cnt_d = CNT_ONE;
      end else if (cnt_q != '1) begin
        cnt_d = cnt_q + CNT_ONE;
      end
    end
    // Registered so the recording level leaves a flop like the other status outputs
    rec_d = (state_d != ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All state holds while the clock enable is low
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
      rec_q <= 1'b0;
      sync_err_q <= 1'b0;
      inv_q <= 1'b0;
      start_q <= 1'b0;
      wvld_q <= 1'b0;
      word_q <= 16'h0000;
      wcmd_q <= 1'b0;
      end_q <= 1'b0;
      abort_q <= 1'b0;
      cnt_q <= '0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      rec_q <= rec_d;
      sync_err_q <= sync_err_d;
      inv_q <= inv_d;
      start_q <= start_d;
      wvld_q <= wvld_d;
      word_q <= word_d;
      wcmd_q <= wcmd_d;
      end_q <= end_d;
      abort_q <= abort_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Time tag latch
  // ----------------------------------------------------------------
  assign st_if.sel = cfg_q[CFG_STAMP_LSB +: 2];
  assign st_if.sync_det = i_sync_det;
  assign st_if.bit_mid = i_bit_mid;
  assign st_if.bit_index = i_bit_index;
  assign st_if.time_tag = i_time_tag;
  assign st_if.clear = begin_rec;
  assign st_if.commit_first = commit_first;
  assign st_if.commit_word = commit_word;

  bmrc_stamp u_stamp (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .st(st_if.unit)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_cfg_rdata = cfg_q;
  assign o_rec_start = start_q;
  assign o_rec_word_vld = wvld_q;
  assign o_rec_word = word_q;
  assign o_rec_word_is_cmd = wcmd_q;
  assign o_rec_end = end_q;
  assign o_rec_abort = abort_q;
  assign o_stamp = st_if.stamp;
  assign o_sync_err = sync_err_q;
  assign o_invalid_err = inv_q;
  assign o_recording = rec_q;
  assign o_word_count = cnt_q;

endmodule : bmrc_top

// ---- bmrc_top_sva.sv ----
// Concurrent checks of the monitor record control at its top ports
`timescale 1ns/1ps
module bmrc_top_sva
  import bmrc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic [15:0] o_cfg_rdata,
  input wire logic i_sync_is_cmd,
  input wire logic i_two_bits,
  input wire logic i_word_done,
  input wire logic i_word_manch_ok,
  input wire logic i_word_parity_ok,
  input wire logic i_word_is_cmd,
  input wire logic i_msg_end,
  input wire logic o_rec_start,
  input wire logic o_rec_word_vld,
  input wire logic o_rec_abort,
  input wire logic [TT_W-1:0] o_stamp,
  input wire logic o_sync_err,
  input wire logic o_invalid_err,
  input wire logic o_recording,
  input wire logic [CNT_W-1:0] o_word_count
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  logic good_w;
  assign good_w = i_word_done && i_word_manch_ok && i_word_parity_ok;
  // ----
  // Record start and stamp
  // ----
  stamp_off_a:
  assert property (o_rec_start && o_cfg_rdata[9:8] == 2'h3 |-> o_stamp == TT_ZERO) else $error("stamp not zero");
  cmd_start_a:
  assert property (!o_recording && i_clk_en && good_w && i_word_is_cmd && o_cfg_rdata[6:5] == 2'h0
    |=> o_rec_start && o_rec_word_vld) else $error("good command did not open record");
  cmd_only_a:
  assert property (o_rec_start && $past(o_cfg_rdata[6:5]) == 2'h0 |-> $past(good_w && i_word_is_cmd))
    else $error("record opened without good command");
  any_sync_a:
  assert property (o_rec_start && $past(o_cfg_rdata[6:5]) == 2'h1 |-> $past(good_w)
    && o_sync_err == !$past(i_word_is_cmd)) else $error("word start or sync flag wrong");
  frag_cmd_a:
  assert property (!o_recording && i_clk_en && i_two_bits && i_sync_is_cmd && o_cfg_rdata[6:5] == 2'h2
    |=> o_rec_start && o_recording) else $error("command fragment did not open record");
  frag_any_a:
  assert property (!o_recording && i_clk_en && i_two_bits && o_cfg_rdata[6:5] == 2'h3
    |=> o_rec_start && o_sync_err == !$past(i_sync_is_cmd)) else $error("fragment start or sync flag wrong");
  // ----
  // Bad words inside a record
  // ----
  abort_a:
  assert property (o_recording && o_word_count != '0 && !o_cfg_rdata[4] && i_word_done && !good_w && i_clk_en
    |=> o_rec_abort && !o_rec_word_vld && !o_recording) else $error("bad word did not abort");
  keep_a:
  assert property (o_recording && o_word_count != '0 && o_cfg_rdata[4] && i_word_done && !good_w && i_clk_en
    && !i_msg_end |=> o_rec_word_vld && o_invalid_err && o_recording) else $error("bad word not kept");
endmodule : bmrc_top_sva

bind bmrc_top bmrc_top_sva u_sva (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .o_cfg_rdata(o_cfg_rdata),
  .i_sync_is_cmd(i_sync_is_cmd), .i_two_bits(i_two_bits), .i_word_done(i_word_done),
  .i_word_manch_ok(i_word_manch_ok), .i_word_parity_ok(i_word_parity_ok), .i_word_is_cmd(i_word_is_cmd),
  .i_msg_end(i_msg_end), .o_rec_start(o_rec_start), .o_rec_word_vld(o_rec_word_vld), .o_rec_abort(o_rec_abort),
  .o_stamp(o_stamp), .o_sync_err(o_sync_err), .o_invalid_err(o_invalid_err), .o_recording(o_recording),
  .o_word_count(o_word_count)
);

// ---- testbench.sv ----
// Self-checking bench of the monitor record control
`timescale 1ns/1ps
module testbench;
  import bmrc_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic cfg_we = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] cfg_wd = 16'h0000;
  logic [TT_W-1:0] tag = 48'h0000_0000_1000;
  logic sync, sync_cmd, mid, two, done, manch, par, wcmd, mend, start, wvld, wiscmd, rend, abort, serr, ierr, rec;
  logic [4:0] idx;
  logic [15:0] data, rdata, rword;
  logic [TT_W-1:0] stamp, t_a, t_b, t_e;
  logic [CNT_W-1:0] wcnt;
  int cnt [4] = '{0, 0, 0, 0};
  int base [4] = '{0, 0, 0, 0};
  int n_errors = 0;
  int total_checks = 0;
  always #20 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    tag <= tag + 48'h0000_0000_0001;
    cnt[0] <= cnt[0] + int'(start);
    cnt[1] <= cnt[1] + int'(wvld);
    cnt[2] <= cnt[2] + int'(rend);
    cnt[3] <= cnt[3] + int'(abort);
  end
  bmrc_top dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(clk_en), .i_cfg_we(cfg_we), .i_cfg_wdata(cfg_wd),
    .o_cfg_rdata(rdata), .i_sync_det(sync), .i_sync_is_cmd(sync_cmd), .i_bit_mid(mid), .i_bit_index(idx),
    .i_two_bits(two), .i_word_done(done), .i_word_manch_ok(manch), .i_word_parity_ok(par), .i_word_is_cmd(wcmd),
    .i_word_data(data), .i_msg_end(mend), .i_time_tag(tag), .o_rec_start(start), .o_rec_word_vld(wvld),
    .o_rec_word(rword), .o_rec_word_is_cmd(wiscmd), .o_rec_end(rend), .o_rec_abort(abort), .o_stamp(stamp),
    .o_sync_err(serr), .o_invalid_err(ierr), .o_recording(rec), .o_word_count(wcnt));
  bmrc_dec_model dec (.i_sys_clk(i_sys_clk), .i_time_tag(tag), .o_sync(sync), .o_sync_cmd(sync_cmd), .o_mid(mid),
    .o_idx(idx), .o_two(two), .o_done(done), .o_manch(manch), .o_par(par), .o_cmd(wcmd), .o_data(data),
    .o_end(mend));
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step();
    @(posedge i_sys_clk);
    #1;
  endtask : step
  task automatic cfg(input logic [15:0] v);
    @(posedge i_sys_clk);
    cfg_we <= 1'b1;
    cfg_wd <= v;
    @(posedge i_sys_clk);
    cfg_we <= 1'b0;
    #1;
    chk("config", 48'(v | 16'h0001), 48'(rdata));
    base = cnt;
  endtask : cfg
  task automatic tally(input int s, input int w, input int e, input int a);
    chk("starts", 48'(s), 48'(cnt[0] - base[0]));
    chk("words", 48'(w), 48'(cnt[1] - base[1]));
    chk("ends", 48'(e), 48'(cnt[2] - base[2]));
    chk("aborts", 48'(a), 48'(cnt[3] - base[3]));
  endtask : tally
  task automatic fin();
    dec.finish();
    step();
  endtask : fin
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // ----
  // Tests
  // ----
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    step();
    chk("reset", 48'(16'h0801), 48'(rdata));
    cfg(16'hFF76);
    cfg(16'h0000);
    @(posedge i_sys_clk);
    clk_en <= 1'b0;
    cfg_we <= 1'b1;
    cfg_wd <= 16'h0100;
    @(posedge i_sys_clk);
    cfg_we <= 1'b0;
    clk_en <= 1'b1;
    step();
    chk("frozen", 48'(16'h0001), 48'(rdata));
    $display("test config done");
    for (int s = 0; s < 4; s++) begin
      cfg(16'(s) << 8);
      dec.send(1'b1, 1'b1, 1'b1, 16'h1234);
      t_a = dec.t_first;
      t_b = dec.t_last;
      dec.send(1'b0, 1'b1, 1'b1, 16'h5678);
      fin();
      t_e = s == 0 ? dec.t_last : s == 1 ? t_a : s == 2 ? t_b : TT_ZERO;
      chk("stamp", t_e, stamp);
      chk("word_count", 48'(6'h02), 48'(wcnt));
      tally(1, 2, 1, 0);
    end
    $display("test stamp done");
    cfg(16'h0000);
    dec.send(1'b0, 1'b1, 1'b1, 16'h0F0F);
    dec.send(1'b1, 1'b1, 1'b0, 16'h0F0F);
    step();
    tally(0, 0, 0, 0);
    cfg(16'h0020);
    dec.send(1'b0, 1'b1, 1'b1, 16'h00FF);
    step();
    chk("sync_err", 48'(1'b1), 48'(serr));
    chk("word", 48'(16'h00FF), 48'(rword));
    chk("word_cmd", 48'(1'b0), 48'(wiscmd));
    fin();
    tally(1, 1, 1, 0);
    $display("test start done");
    cfg(16'h0000);
    dec.send(1'b1, 1'b1, 1'b1, 16'h0001);
    dec.send(1'b0, 1'b0, 1'b1, 16'h0002);
    step();
    chk("recording", 48'(1'b0), 48'(rec));
    chk("kept_word", 48'(16'h0001), 48'(rword));
    chk("kept_cmd", 48'(1'b1), 48'(wiscmd));
    chk("word_count", 48'(6'h01), 48'(wcnt));
    tally(1, 1, 0, 1);
    cfg(16'h0010);
    dec.send(1'b1, 1'b1, 1'b1, 16'h0003);
    dec.send(1'b0, 1'b1, 1'b0, 16'h0004);
    step();
    chk("invalid_err", 48'(1'b1), 48'(ierr));
    chk("recording", 48'(1'b1), 48'(rec));
    fin();
    tally(1, 2, 1, 0);
    $display("test bad word done");
    cfg(16'h0040);
    dec.send(1'b0, 1'b1, 1'b1, 16'h0005);
    dec.send(1'b1, 1'b1, 1'b0, 16'h0006);
    step();
    chk("invalid_err", 48'(1'b1), 48'(ierr));
    fin();
    tally(1, 1, 1, 0);
    cfg(16'h0060);
    dec.send(1'b0, 1'b1, 1'b1, 16'h0007);
    step();
    chk("sync_err", 48'(1'b1), 48'(serr));
    chk("invalid_err", 48'(1'b0), 48'(ierr));
    fin();
    tally(1, 1, 1, 0);
    $display("test fragment done");
    summarize();
  end
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    n_errors++;
    $display("watchdog expired");
    summarize();
  end
endmodule : testbench
